// >>> logic/lsr_readout_seq.sv
// Readout and integration sequencer of a 128 pixel line sensor, with APB status access.
// Notes on behaviour
// - After power-on reset all capacitors discharge and every stage samples.
// - A pixel clock rise with start high begins readout and integration.
// - Main hold rises on the trigger edge; last-pixel hold one clock later.
// - Integrator reset low for one clock, second to third falling edge.
// - Main hold drops after pixel 127; last-pixel hold one clock later.
// - A full readout takes exactly 128 pixel clocks from the start.
// - Start before clock 128 restarts output at pixel 1 at once.
// - On such a restart the hold capacitors keep their held values.
// - Beyond 128 clocks pixel 1 is output in sample mode, tracking.
// - Shutter high disconnects photodiodes and keeps capacitor voltages.
// - Shutter low keeps accumulating photocurrent until the next start.
// - From pixel 1 each held voltage goes to the output, one per clock.
`timescale 1ns/1ns
`default_nettype none
module lsr_readout_seq
    import lsr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Controller pins, asynchronous to clk.
    input wire lsr_pkg::lsr_pins_t pins,
    // Array switch controls.
    output var lsr_pkg::lsr_array_t array,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lsr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import lsr_pkg::*;

    // The sampler needs four clk cycles per pixel clock period; refuse slower clocks.
    if (CLK_FREQ_HZ / PIX_CLK_MAX_HZ < MIN_SAMPLES) begin : gClkTooSlow
        $error("clk too slow to sample the pixel clock");
    end

    logic pixSync1_ff, pixSync2_ff, pixPrev_ff;
    logic startSync1_ff, startSync2_ff;
    logic shutSync1_ff, shutSync2_ff;
    logic pixRise, pixFall, startEff, shutterEff;
    lsr_state_t state_ff;
    logic [CNT_W-1:0] clkCount_ff;
    logic [IDX_W-1:0] pixelIndex_ff;
    logic holdMain_ff, holdLast_ff, intRstN_ff;
    logic [1:0] fallCnt_ff;
    logic [1:0] ctrl_ff;
    logic [15:0] runs_ff, restarts_ff;
    logic [31:0] prdata_ff;
    logic trigger, restart, stepRun, runEnd;

    // Two flip-flop synchronisers on every pin; first stages feed only second stages.
    // sampling headroom
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pixSync1_ff <= 1'b0;
            pixSync2_ff <= 1'b0;
            pixPrev_ff <= 1'b0;
            startSync1_ff <= 1'b0;
            startSync2_ff <= 1'b0;
            shutSync1_ff <= 1'b0;
            shutSync2_ff <= 1'b0;
        end else begin
            pixSync1_ff <= pins.pixClk;
            pixSync2_ff <= pixSync1_ff;
            pixPrev_ff <= pixSync2_ff;
            startSync1_ff <= pins.startPulse;
            startSync2_ff <= startSync1_ff;
            shutSync1_ff <= pins.shutterDisable;
            shutSync2_ff <= shutSync1_ff;
        end
    end

    // Edge detection and event decode; start and clock share the same latency.
    assign pixRise = pixSync2_ff & ~pixPrev_ff;
    assign pixFall = ~pixSync2_ff & pixPrev_ff;
    assign startEff = startSync2_ff & ~ctrl_ff[CTRL_START_MASK_BIT];
    assign shutterEff = shutSync2_ff | ctrl_ff[CTRL_SHUTTER_BIT];
    assign trigger = pixRise & startEff;
    assign restart = trigger & (state_ff == LSR_READ) & (clkCount_ff < CNT_RUN_END);
    assign stepRun = pixRise & ~startEff & (state_ff == LSR_READ);
    assign runEnd = stepRun & (clkCount_ff == CNT_RUN_END);

    // Sequencer state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= LSR_IDLE;
        end else begin
            case (state_ff)
                LSR_IDLE, LSR_OVER: begin
                    if (trigger) begin
                        state_ff <= LSR_READ;
                    end
                end
                LSR_READ: begin
                    if (runEnd) begin
                        state_ff <= LSR_OVER;
                    end
                end
                default: begin
                    state_ff <= LSR_IDLE;
                end
            endcase
        end
    end

    // Clock counter and output pixel index; the index returns to the first pixel after the last pixel.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clkCount_ff <= CNT_ZERO;
            pixelIndex_ff <= IDX_FIRST;
        end else if (trigger) begin
            clkCount_ff <= CNT_FIRST;
            pixelIndex_ff <= IDX_FIRST;
        end else if (runEnd) begin
            clkCount_ff <= CNT_ZERO;
            pixelIndex_ff <= IDX_FIRST;
        end else if (stepRun) begin
            clkCount_ff <= clkCount_ff + CNT_FIRST;
            pixelIndex_ff <= clkCount_ff[IDX_W-1:0];
        end
    end

    // Hold switches. A restart leaves them alone so held values survive.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdMain_ff <= 1'b0;
            holdLast_ff <= 1'b0;
        end else if (trigger && !restart) begin
            holdMain_ff <= 1'b1;
            holdLast_ff <= 1'b0;
        end else if (stepRun) begin
            if (clkCount_ff == CNT_FIRST) begin
                holdLast_ff <= 1'b1;
            end
            if (clkCount_ff == CNT_MAIN_LAST) begin
                holdMain_ff <= 1'b0;
            end
            if (clkCount_ff == CNT_RUN_END) begin
                holdLast_ff <= 1'b0;
            end
        end
    end

    // Integrator reset: low from the second to the third falling edge of a run.
    // Held low during power-on reset so the capacitors start discharged.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fallCnt_ff <= 2'h0;
            intRstN_ff <= 1'b0;
        end else if (trigger) begin
            fallCnt_ff <= 2'h0;
            intRstN_ff <= 1'b1;
        end else if (pixFall && state_ff == LSR_READ && fallCnt_ff != FALL_RST_OFF) begin
            fallCnt_ff <= fallCnt_ff + 2'h1;
            intRstN_ff <= (fallCnt_ff + 2'h1) != FALL_RST_ON;
        end else if (state_ff == LSR_IDLE) begin
            intRstN_ff <= 1'b1;
        end
    end

    // Array outputs, all from flip-flops except the shutter gate and the trackSample state decode.
    always_comb begin
        array.holdSelectMain = holdMain_ff;
        array.holdSelectLast = holdLast_ff;
        array.integratorResetN = intRstN_ff;
        array.pixelIndex = pixelIndex_ff;
        array.trackSample = (state_ff != LSR_READ);
        array.integrate = ~shutterEff;
    end

    // Event counters for software; they wrap rather than saturate.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runs_ff <= EVT_ZERO;
            restarts_ff <= EVT_ZERO;
        end else begin
            if (runEnd) begin
                runs_ff <= runs_ff + 16'h0001;
            end
            if (restart) begin
                restarts_ff <= restarts_ff + 16'h0001;
            end
        end
    end

    // APB decode: zero wait states, unmapped addresses answer with pslverr.
    function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RUNS) || (a == REG_RESTARTS);
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addrMapped(paddr);
    assign prdata = prdata_ff;

    // Control register write, taken in the access phase.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= WORD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= WORD_ZERO;
            case (paddr)
                REG_CTRL: prdata_ff[1:0] <= ctrl_ff;
                REG_STATUS: begin
                    prdata_ff[IDX_W-1:0] <= pixelIndex_ff;
                    prdata_ff[ST_HOLD_MAIN] <= holdMain_ff;
                    prdata_ff[ST_HOLD_LAST] <= holdLast_ff;
                    prdata_ff[ST_INT_RST_N] <= intRstN_ff;
                    prdata_ff[ST_READING] <= (state_ff == LSR_READ);
                    prdata_ff[ST_TRACKING] <= (state_ff == LSR_OVER);
                    prdata_ff[ST_INTEGRATING] <= ~shutterEff;
                end
                REG_RUNS: prdata_ff[15:0] <= runs_ff;
                REG_RESTARTS: prdata_ff[15:0] <= restarts_ff;
                default: prdata_ff <= WORD_ZERO;
            endcase
        end
    end

    // Checks on the sequencer.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_IDLE_SAMPLE: assert property (
        state_ff == LSR_IDLE |-> !holdMain_ff && !holdLast_ff)
        else $error("holds not in sample mode while idle");
    AST_TRIGGER_READ: assert property (
        trigger |=> state_ff == LSR_READ && clkCount_ff == CNT_FIRST)
        else $error("trigger did not start a readout");
    AST_HOLD_MAIN_ON: assert property (
        trigger && state_ff != LSR_READ |=> holdMain_ff && !holdLast_ff)
        else $error("main hold not set on trigger");
    AST_HOLD_LAST_LAG: assert property (
        stepRun && clkCount_ff == CNT_FIRST |=> holdLast_ff && holdMain_ff)
        else $error("last hold did not follow one clock later");
    AST_RST_WINDOW: assert property (
        $fell(intRstN_ff) |-> fallCnt_ff == FALL_RST_ON && state_ff == LSR_READ)
        else $error("integrator reset outside its falling edge window");
    AST_RST_END: assert property (
        !intRstN_ff && pixFall && state_ff == LSR_READ |=> intRstN_ff)
        else $error("integrator reset longer than one clock");
    AST_HOLD_RELEASE: assert property (
        stepRun && clkCount_ff == CNT_MAIN_LAST |=> !holdMain_ff ##0 holdLast_ff)
        else $error("main hold not released after pixel 127");
    AST_RUN_END: assert property (
        runEnd |=> state_ff == LSR_OVER && !holdLast_ff)
        else $error("run did not end after 128 clocks");
    AST_RESTART_IDX: assert property (
        restart |=> pixelIndex_ff == IDX_FIRST && clkCount_ff == CNT_FIRST)
        else $error("restart did not return to pixel 1");
    AST_RESTART_HOLD: assert property (
        restart |=> holdMain_ff == $past(holdMain_ff) && holdLast_ff == $past(holdLast_ff))
        else $error("restart disturbed the hold switches");
    AST_OVER_TRACK: assert property (
        state_ff == LSR_OVER |-> pixelIndex_ff == IDX_FIRST && array.trackSample)
        else $error("overrun not tracking pixel 1");
    AST_SHUTTER: assert property (
        $rose(shutSync2_ff) |-> !array.integrate)
        else $error("shutter did not stop integration");
    AST_INDEX_STEP: assert property (
        stepRun && clkCount_ff < CNT_RUN_END |=> pixelIndex_ff == $past(clkCount_ff[IDX_W-1:0]))
        else $error("pixel index did not step by one");

    COV_FULL_RUN: cover property (runEnd);
    COV_RESTART: cover property (restart && holdMain_ff);
    COV_OVERRUN_RETRIGGER: cover property (state_ff == LSR_OVER ##1 trigger);
    COV_SHUTTER_IN_RUN: cover property (shutterEff && state_ff == LSR_READ);
endmodule
`default_nettype wire

// >>> logic/lsr_pkg.sv
// Shared constants and carrier types for the line sensor readout sequencer.
package lsr_pkg;
    // Pixel geometry.
    localparam int PIXEL_COUNT = 128;
    localparam int IDX_W = 7;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_FIRST = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAIN_LAST = 8'h7F;
    localparam logic [CNT_W-1:0] CNT_RUN_END = 8'h80;
    localparam logic [IDX_W-1:0] IDX_FIRST = 7'h00;
    // Falling edges counted inside a run; reset pulse spans the second to the third.
    localparam logic [1:0] FALL_RST_ON = 2'h2;
    localparam logic [1:0] FALL_RST_OFF = 2'h3;
    // Clock rates; the pixel clock must be sampled at least four times per period.
    localparam longint CLK_FREQ_HZ = 20000000;
    localparam longint PIX_CLK_MAX_HZ = 5000000;
    localparam int MIN_SAMPLES = 4;
    // APB register map, byte addresses.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_RUNS = 12'h008;
    localparam logic [ADDR_W-1:0] REG_RESTARTS = 12'h00C;
    // Control field positions and reset value.
    localparam int CTRL_SHUTTER_BIT = 0;
    localparam int CTRL_START_MASK_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status field positions.
    localparam int ST_HOLD_MAIN = 7;
    localparam int ST_HOLD_LAST = 8;
    localparam int ST_INT_RST_N = 9;
    localparam int ST_READING = 10;
    localparam int ST_TRACKING = 11;
    localparam int ST_INTEGRATING = 12;
    localparam logic [15:0] EVT_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Sequencer states, Gray coded along idle, reading, overrun.
    typedef enum logic [1:0] {
        LSR_IDLE = 2'b00,
        LSR_READ = 2'b01,
        LSR_OVER = 2'b11
    } lsr_state_t;

    // Control pins driven by the external controller.
    typedef struct packed {
        logic startPulse;
        logic pixClk;
        logic shutterDisable;
    } lsr_pins_t;

    // Switch controls toward the analogue pixel array.
    typedef struct packed {
        logic holdSelectMain;
        logic holdSelectLast;
        logic integratorResetN;
        logic [IDX_W-1:0] pixelIndex;
        logic trackSample;
        logic integrate;
    } lsr_array_t;
endpackage

// >>> bench/lsr_ctrl_model.sv
// Behavioural model of the external controller driving start, pixel clock and shutter.
`timescale 1ns/1ns
`default_nettype none
module lsr_ctrl_model
    import lsr_pkg::*;
#(
    parameter int HALF = 5
)
(
    // Clock.
    input wire logic clk,
    // Sensor control pins.
    output var lsr_pkg::lsr_pins_t pins
);
    // The pins have pull-downs, so every line idles low and the pixel clock stands still.
    initial begin
        pins = '0;
    end

    // One pixel clock period, optionally with a start request set up before the rise.
    // rate limit: at least 2*HALF+2 system clocks per period stays at or below 5 MHz.
    task automatic step(input logic withStart);
        // start request: start is raised before the rise and held past it.
        @(posedge clk) pins.startPulse <= withStart;
        @(posedge clk) pins.pixClk <= 1'b1;
        repeat (HALF) @(posedge clk);
        pins.pixClk <= 1'b0;
        pins.startPulse <= 1'b0;
        // clock supply: the caller issues one step per pixel wanted.
        repeat (HALF) @(posedge clk);
    endtask

    // Move the shutter pin and give the synchroniser time to pass it on.
    task automatic shut(input logic v);
        @(posedge clk) pins.shutterDisable <= v;
        repeat (HALF) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/lsr_readout_seq_tb.sv
// Self-checking testbench for the line sensor readout sequencer.
`timescale 1ns/1ns
`default_nettype none
module lsr_readout_seq_tb;
    import lsr_pkg::*;
    logic clk;
    logic resetn;
    lsr_pins_t pins;
    lsr_array_t array;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    int n_errors;
    int n_compared;
    logic [ADDR_W-1:0] regAddr [4] = '{REG_CTRL, REG_STATUS, REG_RUNS, REG_RESTARTS};
    logic [31:0] regRst [4] = '{32'h0000_0000, 32'h0000_1200, 32'h0000_0000, 32'h0000_0000};

    // Free-running 20 MHz system clock.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    lsr_readout_seq lsr_readout_seq_inst (.clk(clk), .resetn(resetn), .pins(pins),
        .array(array), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lsr_ctrl_model lsr_ctrl_model_inst (.clk(clk), .pins(pins));

    // Compare one value and count the outcome.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; the access phase lasts until pready is seen high, under a bound.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Observed array controls, packed as hold main, hold last, reset, tracking, index.
    function automatic logic [31:0] obs();
        return 32'({array.holdSelectMain, array.holdSelectLast, array.integratorResetN,
            array.trackSample, array.pixelIndex});
    endfunction

    // Expected array controls k pixel clock rises after the triggering rise.
    function automatic logic [31:0] expk(input int k);
        logic [6:0] ix;
        ix = (k <= 127) ? 7'(k) : 7'h00;
        return 32'({k <= 126, k >= 1 && k <= 127, k != 1, k >= 128, ix});
    endfunction

    // Pixel clock step followed by a settled look at the array controls.
    task automatic stepk(input logic s, input int k);
        lsr_ctrl_model_inst.step(s);
        @(negedge clk);
        check("array", obs(), expk(k));
    endtask

    initial begin
        n_errors = 0;
        n_compared = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check("array after reset", obs(), 32'h0000_0080);
        check("integrate after reset", 32'(array.integrate), 32'h0000_0001);
        // Reset values, an unmapped place and a write to a read-only place.
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, regAddr[i], 32'h0000_0000);
            check("register reset", rd, regRst[i]);
        end
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped error", 32'(err), 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check("status read only", rd, 32'h0000_1200);
        // Full run, then clocking on past its end.
        stepk(1'b1, 0);
        for (int k = 1; k <= 129; k++) begin
            stepk(1'b0, k);
        end
        apb(1'b0, REG_RUNS, 32'h0000_0000);
        check("runs", rd, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check("status overrun", rd, 32'h0000_1A00);
        // Early restart keeps both holds and begins output at pixel 1 again.
        stepk(1'b1, 0);
        for (int k = 1; k <= 10; k++) begin
            stepk(1'b0, k);
        end
        lsr_ctrl_model_inst.step(1'b1);
        @(negedge clk);
        check("restart", obs(), 32'h0000_0700);
        lsr_ctrl_model_inst.step(1'b0);
        @(negedge clk);
        check("restart next", obs(), 32'h0000_0601);
        apb(1'b0, REG_RESTARTS, 32'h0000_0000);
        check("restarts", rd, 32'h0000_0001);
        // Start ignored while masked: the run just carries on.
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        check("ctrl", rd, 32'h0000_0002);
        lsr_ctrl_model_inst.step(1'b1);
        @(negedge clk);
        check("masked start", obs(), 32'h0000_0702);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check("status in run", rd, 32'h0000_1782);
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        // Shutter pin and forced shutter both disconnect the photodiodes.
        lsr_ctrl_model_inst.shut(1'b1);
        @(negedge clk);
        check("shutter high", 32'(array.integrate), 32'h0000_0000);
        lsr_ctrl_model_inst.shut(1'b0);
        @(negedge clk);
        check("shutter low", 32'(array.integrate), 32'h0000_0001);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        @(negedge clk);
        check("forced shutter", 32'(array.integrate), 32'h0000_0000);
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        @(negedge clk);
        check("shutter off", 32'(array.integrate), 32'h0000_0001);
        end_of_test();
    end
endmodule
`default_nettype wire
